// [core/mrm_cfg.svh]
// Constants for the mode and resource map control block.
// Overview of operation
// R01 - Expanded wide: port A high, port B low.
// R02 - Expanded narrow: address on A/B, data on A.
// R03 - Single-chip: no bus, ports are general I/O.
// R04 - Reset enables port E pullups, not A/B.
// R05 - Special wide: port E pins are bus control.
// R06 - Special narrow: split words, high byte first; split writes drive the low byte in both halves.
// R07 - Special single-chip: skip vector, enter debug.
// R08 - Peripheral mode: CPU idle, fixed until reset.
// R09 - Debug enabled first, then command or instruction.
// R10 - Active debug maps ROM at FF00-FFFF.
// R11 - Debug accesses use idle bus cycles.
// R12 - Normal modes: position registers written once.
// R13 - Mapping writes take effect one cycle later.
// R14 - Decode priority: debug, regs, RAM, EEPROM, flash, external.
// R15 - Expanded modes: unclaimed addresses go external.
// R16 - Mode register at 000B, hidden in peripheral.
// R17 - Mode bits latched from pins at reset release.
// R18 - Special bit and mode bits have guarded writes.
// R19 - Stretch bit controls E clock stretching.
// R20 - Visibility shows internal accesses on the bus.
// R21 - Visibility bit: once normal, special skips first.
// R22 - Pin code decodes into eight modes.
// R23 - Pull resistors on mode pins during reset.
`ifndef MRM_CFG_SVH
`define MRM_CFG_SVH
`define MRM_IDX_MODE 6'h0b
`define MRM_IDX_RAM_POS 6'h10
`define MRM_IDX_REG_POS 6'h11
`define MRM_IDX_EE_POS 6'h12
`define MRM_IDX_MISC 6'h13
`define MRM_IDX_DBG 6'h20
`define MRM_MODE_SSC 3'h0
`define MRM_MODE_SXN 3'h1
`define MRM_MODE_SPR 3'h2
`define MRM_MODE_SXW 3'h3
`define MRM_MODE_NSC 3'h4
`define MRM_MODE_NXN 3'h5
`define MRM_MODE_RSV 3'h6
`define MRM_MODE_NXW 3'h7
`define MRM_BIT_SPECIAL_N 7
`define MRM_BIT_STRETCH 4
`define MRM_BIT_VIS 3
`define MRM_BIT_EBSWAI 2
`define MRM_BIT_EMU_PORT 0
`define MRM_RST_REG_POS 5'h00
`define MRM_RST_RAM_POS 5'h01
`define MRM_RST_EE_POS 4'h0
`define MRM_DBG_BASE 16'hff00
`define MRM_DBG_REG_TOP 16'hff06
`define MRM_EE_LOW 12'hd00
`endif

// [core/mrm_pkg.sv]
// Types for the mode and resource map control block.
package mrm_pkg;
  typedef enum logic [2:0] {
    RES_NONE, RES_DBG_ROM, RES_DBG_REG, RES_REG, RES_RAM, RES_EEPROM, RES_FLASH, RES_EXT
  } mrm_res_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA, BUS_DATA_LO} mrm_bus_t;
endpackage

// [core/mrm_mode_map.sv]
// Operating mode control, resource decoder and external bus port steering.
`timescale 1ns/1ps
`include "mrm_cfg.svh"
module mrm_mode_map
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Avalon-MM register slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Mode pins and their reset pulls.
  input wire logic backgroundDebugPin,
  input wire logic modeSelectB,
  input wire logic modeSelectA,
  output logic dbgPinPullUpEn,
  output logic modePinPullDownEn,
  // CPU access.
  input wire logic cpuValid,
  input wire logic cpuWrite,
  input wire logic cpuWide,
  input wire logic [15:0] cpuAddr,
  input wire logic [15:0] cpuWdata,
  output logic cpuReady,
  output logic [15:0] extRdata,
  output mrm_pkg::mrm_res_t cpuResource,
  // Non-intrusive debug access.
  input wire logic dbgReq,
  input wire logic dbgWrite,
  input wire logic [15:0] dbgAddr,
  output logic dbgGrant,
  output mrm_pkg::mrm_res_t dbgResource,
  // Background debug control.
  input wire logic serialEntryCmd,
  input wire logic backgroundEntryInstruction,
  input wire logic dbgExit,
  output logic backgroundDebugMode,
  output logic skipResetVector,
  output logic cpuHalt,
  // E clock control.
  output logic eStretchHigh,
  output logic eStretchLow,
  // General-purpose port data from the port registers.
  input wire logic [7:0] gpioAOut,
  input wire logic [7:0] gpioADir,
  input wire logic [7:0] gpioBOut,
  input wire logic [7:0] gpioBDir,
  input wire logic [7:0] gpioEDir,
  // Port pins.
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portBIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOeN,
  output logic [7:0] portBOut,
  output logic [7:0] portBOeN,
  output logic [7:0] portEOeN,
  output logic [7:2] portEBusCtl,
  output logic portEPullEn,
  output logic portABPullEn,
  output logic lowByteStrobe
);
  import mrm_pkg::*;

  // ==========================================================
  // Mode state.
  logic capturedFf;
  logic [2:0] modeFf;
  logic stretchFf;
  logic visFf;
  logic ebswaiFf;
  logic emuPortFf;
  logic modeWrittenFf;
  logic special;
  logic peripheral;
  logic expanded;
  logic narrow;
  logic modeWr;
  logic [2:0] nxt_mode;

  assign special = ~modeFf[2];
  assign peripheral = (modeFf == `MRM_MODE_SPR) || (modeFf == `MRM_MODE_RSV); // see R22
  assign expanded = modeFf[0];
  assign narrow = expanded && !modeFf[1];

  // Mode pin pulls stay on only until the pin levels are caught; the port E and A/B pulls keep their reset levels.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dbgPinPullUpEn <= 1'b1; // see R23
      modePinPullDownEn <= 1'b1; // see R23
      portEPullEn <= 1'b1; // see R04
      portABPullEn <= 1'b0; // see R04
    end
    else
    begin
      dbgPinPullUpEn <= 1'b0;
      modePinPullDownEn <= 1'b0;
      portEPullEn <= 1'b1;
      portABPullEn <= 1'b0;
    end
  end

  // Mode register write decode with the guarded mode field.
  assign modeWr = avs_write && !avs_waitrequest && avs_address == `MRM_IDX_MODE && !peripheral;
  always_comb
  begin
    nxt_mode = modeFf;
    if (special && modeWrittenFf && avs_writedata[`MRM_BIT_SPECIAL_N]) // see R18
    begin
      nxt_mode[2] = 1'b1;
    end
    if (special || !modeWrittenFf) // see R18
    begin
      nxt_mode[1:0] = avs_writedata[6:5];
    end
    if (nxt_mode == `MRM_MODE_SPR || nxt_mode == `MRM_MODE_RSV) // see R18
    begin
      nxt_mode = modeFf;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      capturedFf <= 1'b0;
      modeFf <= `MRM_MODE_NSC;
      stretchFf <= 1'b1;
      visFf <= 1'b0;
      ebswaiFf <= 1'b0;
      emuPortFf <= 1'b0;
      modeWrittenFf <= 1'b0;
    end
    else if (!capturedFf)
    begin
      capturedFf <= 1'b1;
      modeFf <= {backgroundDebugPin, modeSelectB, modeSelectA}; // see R17
      stretchFf <= 1'b1; // see R17
      visFf <= ~backgroundDebugPin; // see R17
      emuPortFf <= ~backgroundDebugPin; // see R17
    end
    else if (modeWr)
    begin
      modeWrittenFf <= 1'b1;
      modeFf <= nxt_mode;
      if (!expanded && (special || !modeWrittenFf))
      begin
        stretchFf <= avs_writedata[`MRM_BIT_STRETCH]; // see R19
      end
      if (special ? modeWrittenFf : !modeWrittenFf)
      begin
        visFf <= avs_writedata[`MRM_BIT_VIS]; // see R21
        emuPortFf <= avs_writedata[`MRM_BIT_EMU_PORT];
      end
      if (!special)
      begin
        ebswaiFf <= avs_writedata[`MRM_BIT_EBSWAI];
      end
    end
    else if (expanded)
    begin
      stretchFf <= 1'b1; // see R19
    end
  end

  // ==========================================================
  // Mapping registers with a one-cycle delayed active copy.
  logic [4:0] regPosFf;
  logic [4:0] ramPosFf;
  logic [3:0] eePosFf;
  logic eeOnFf;
  logic mapRomFf;
  logic romOnFf;
  logic [3:0] posWrittenFf;
  logic [4:0] regPosActFf;
  logic [4:0] ramPosActFf;
  logic [3:0] eePosActFf;
  logic eeOnActFf;
  logic mapRomActFf;
  logic romOnActFf;
  logic busWr;

  assign busWr = avs_write && !avs_waitrequest && capturedFf;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regPosFf <= `MRM_RST_REG_POS;
      ramPosFf <= `MRM_RST_RAM_POS;
      eePosFf <= `MRM_RST_EE_POS;
      eeOnFf <= 1'b1;
      mapRomFf <= 1'b1;
      romOnFf <= 1'b1;
      posWrittenFf <= 4'h0;
    end
    else if (!capturedFf)
    begin
      mapRomFf <= ~backgroundDebugPin | ~modeSelectA;
      romOnFf <= ~modeSelectA;
    end
    else if (busWr)
    begin
      if (avs_address == `MRM_IDX_REG_POS && (special || !posWrittenFf[0])) // see R12
      begin
        regPosFf <= avs_writedata[7:3];
        posWrittenFf[0] <= 1'b1;
      end
      if (avs_address == `MRM_IDX_RAM_POS && (special || !posWrittenFf[1])) // see R12
      begin
        ramPosFf <= avs_writedata[7:3];
        posWrittenFf[1] <= 1'b1;
      end
      if (avs_address == `MRM_IDX_EE_POS)
      begin
        if (special || !posWrittenFf[2]) // see R12
        begin
          eePosFf <= avs_writedata[7:4];
          posWrittenFf[2] <= 1'b1;
        end
        if (expanded || peripheral)
        begin
          eeOnFf <= avs_writedata[0];
        end
      end
      if (avs_address == `MRM_IDX_MISC && (special || !posWrittenFf[3]))
      begin
        mapRomFf <= avs_writedata[1];
        romOnFf <= avs_writedata[0];
        posWrittenFf[3] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regPosActFf <= `MRM_RST_REG_POS;
      ramPosActFf <= `MRM_RST_RAM_POS;
      eePosActFf <= `MRM_RST_EE_POS;
      eeOnActFf <= 1'b1;
      mapRomActFf <= 1'b1;
      romOnActFf <= 1'b1;
    end
    else
    begin
      regPosActFf <= regPosFf; // see R13
      ramPosActFf <= ramPosFf; // see R13
      eePosActFf <= eePosFf; // see R13
      eeOnActFf <= eeOnFf | ~expanded;
      mapRomActFf <= mapRomFf;
      romOnActFf <= romOnFf;
    end
  end

  // ==========================================================
  // Background debug.
  logic dbgEnableFf;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dbgEnableFf <= 1'b0;
      backgroundDebugMode <= 1'b0;
    end
    else if (!capturedFf)
    begin
      dbgEnableFf <= ~(backgroundDebugPin | modeSelectB | modeSelectA); // see R07
      backgroundDebugMode <= ~(backgroundDebugPin | modeSelectB | modeSelectA); // see R07
    end
    else
    begin
      if (busWr && avs_address == `MRM_IDX_DBG)
      begin
        dbgEnableFf <= avs_writedata[7];
      end
      if (dbgEnableFf && !peripheral && (serialEntryCmd || backgroundEntryInstruction)) // see R09
      begin
        backgroundDebugMode <= 1'b1;
      end
      else if (dbgExit)
      begin
        backgroundDebugMode <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      skipResetVector <= 1'b0;
      cpuHalt <= 1'b1;
    end
    else
    begin
      skipResetVector <= capturedFf && modeFf == `MRM_MODE_SSC; // see R07
      cpuHalt <= !capturedFf || peripheral; // see R08
    end
  end

  // ==========================================================
  // Address decoder.
  function automatic mrm_res_t decode(input logic [15:0] a);
    mrm_res_t r;
    r = RES_NONE;
    if (expanded)
    begin
      r = RES_EXT; // see R15
    end
    if (romOnActFf && a[15] == mapRomActFf)
    begin
      r = RES_FLASH;
    end
    if (eeOnActFf && a[15:12] == eePosActFf && a[11:0] >= `MRM_EE_LOW)
    begin
      r = RES_EEPROM;
    end
    if (a[15:11] == ramPosActFf && !a[10])
    begin
      r = RES_RAM;
    end
    if (a[15:11] == regPosActFf && a[10:9] == 2'b00)
    begin
      r = RES_REG;
    end
    if (backgroundDebugMode && a >= `MRM_DBG_BASE) // see R10
    begin
      r = (a <= `MRM_DBG_REG_TOP) ? RES_DBG_REG : RES_DBG_ROM;
    end
    return r; // see R14
  endfunction

  mrm_res_t cpuRes;
  mrm_res_t dbgRes;
  logic dbgOk;
  always_comb
  begin
    cpuRes = decode(cpuAddr);
    dbgRes = decode(dbgAddr);
  end
  assign dbgOk = dbgRes == RES_REG || dbgRes == RES_RAM || !dbgWrite && (dbgRes == RES_EEPROM
    || dbgRes == RES_FLASH);
  assign dbgGrant = dbgReq && !cpuValid && dbgOk && capturedFf && !peripheral; // see R11

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpuResource <= RES_NONE;
      dbgResource <= RES_NONE;
    end
    else
    begin
      cpuResource <= cpuRes;
      dbgResource <= dbgGrant ? dbgRes : RES_NONE; // see R11
    end
  end

  // ==========================================================
  // External bus sequencer and port steering.
  mrm_bus_t busFf;
  logic [15:0] busAddrFf;
  logic [15:0] busWdataFf;
  logic busWriteFf;
  logic busSplitFf;
  logic busWideFf;
  logic isExt;
  logic visible;
  logic needBus;
  logic splitNow;

  assign isExt = cpuRes == RES_EXT;
  assign visible = visFf && expanded && modeFf != `MRM_MODE_NXN; // see R20
  assign needBus = cpuValid && capturedFf && !peripheral && (isExt || visible);
  assign splitNow = cpuWide && narrow && !(visible && !isExt && modeFf == `MRM_MODE_SXN); // see R06
  assign cpuReady = cpuValid && (busFf == BUS_IDLE ? !needBus : (busFf == BUS_DATA_LO ||
    busFf == BUS_DATA && !busSplitFf));
  assign eStretchHigh = stretchFf && busFf != BUS_IDLE; // see R19
  assign eStretchLow = stretchFf && cpuValid && !needBus; // see R19

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busFf <= BUS_IDLE;
      busAddrFf <= 16'h0000;
      busWdataFf <= 16'h0000;
      busWriteFf <= 1'b0;
      busSplitFf <= 1'b0;
      busWideFf <= 1'b0;
      extRdata <= 16'h0000;
    end
    else
    begin
      case (busFf)
        BUS_IDLE:
        begin
          if (needBus)
          begin
            busFf <= BUS_ADDR;
            busAddrFf <= cpuAddr;
            busWdataFf <= cpuWdata;
            busWriteFf <= cpuWrite;
            busSplitFf <= splitNow;
            busWideFf <= cpuWide && !narrow || !splitNow && cpuWide;
          end
        end
        BUS_ADDR:
        begin
          busFf <= BUS_DATA;
        end
        BUS_DATA:
        begin
          if (narrow && !busWideFf)
          begin
            extRdata <= {portAIn, portAIn}; // see R02
          end
          else
          begin
            extRdata <= {portAIn, portBIn}; // see R01
          end
          busFf <= busSplitFf ? BUS_DATA_LO : BUS_IDLE; // see R06
        end
        BUS_DATA_LO:
        begin
          extRdata[7:0] <= portAIn; // see R06
          busFf <= BUS_IDLE;
        end
        default:
        begin
          busFf <= BUS_IDLE;
        end
      endcase
    end
  end

  // Port pins: each bus phase is set up one state ahead, general I/O otherwise.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portAOut <= 8'h00;
      portAOeN <= 8'hff;
      portBOut <= 8'h00;
      portBOeN <= 8'hff;
      portEOeN <= 8'hff;
      portEBusCtl <= 6'h00;
      lowByteStrobe <= 1'b1;
    end
    else if (!capturedFf || !expanded && !peripheral)
    begin
      portAOut <= gpioAOut; // see R03
      portAOeN <= ~gpioADir; // see R03
      portBOut <= gpioBOut;
      portBOeN <= ~gpioBDir;
      portEOeN <= {~gpioEDir[7:2], 2'b11}; // see R03
      portEBusCtl <= 6'h00;
      lowByteStrobe <= 1'b1;
    end
    else
    begin
      portEOeN <= 8'hff;
      portEBusCtl <= (modeFf == `MRM_MODE_SXW) ? 6'h3f : {~emuPortFf, 5'h1f}; // see R05
      lowByteStrobe <= !(busWideFf || busSplitFf);
      case (busFf)
        BUS_IDLE:
        begin
          portAOut <= cpuAddr[15:8];
          portBOut <= cpuAddr[7:0];
          portAOeN <= {8{!needBus}};
          portBOeN <= (needBus || narrow) ? 8'h00 : 8'hff;
        end
        BUS_ADDR:
        begin
          portAOut <= narrow && !busWideFf ? busWdataFf[7:0] : busWdataFf[15:8];
          portBOut <= busWdataFf[7:0];
          portAOeN <= {8{!busWriteFf}};
          portBOeN <= {8{!busWriteFf || narrow && !busWideFf}};
        end
        BUS_DATA:
        begin
          portAOut <= busWdataFf[7:0]; // see R06
          portAOeN <= {8{!busWriteFf || !busSplitFf}};
          portBOeN <= (narrow && !busSplitFf) ? 8'h00 : 8'hff;
        end
        default:
        begin
          portAOeN <= 8'hff;
          portBOeN <= narrow ? 8'h00 : 8'hff;
        end
      endcase
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, read data registered.
  logic ackFf;
  assign avs_waitrequest = (avs_read || avs_write) && !ackFf;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ackFf <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ackFf <= (avs_read || avs_write) && !ackFf;
      if (avs_read && !ackFf)
      begin
        case (avs_address)
          `MRM_IDX_MODE: avs_readdata <= peripheral ? 32'h0 : {24'h0, modeFf, stretchFf, visFf,
            ebswaiFf, 1'b0, emuPortFf}; // see R16
          `MRM_IDX_REG_POS: avs_readdata <= {24'h0, regPosFf, 3'h0};
          `MRM_IDX_RAM_POS: avs_readdata <= {24'h0, ramPosFf, 3'h0};
          `MRM_IDX_EE_POS: avs_readdata <= {24'h0, eePosFf, 3'h0, eeOnFf};
          `MRM_IDX_MISC: avs_readdata <= {30'h0, mapRomFf, romOnFf};
          `MRM_IDX_DBG: avs_readdata <= {24'h0, dbgEnableFf, backgroundDebugMode, 6'h0};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// [bench/mrm_mode_map_monitor.sv]
// Checker for the ports of the mode and resource map control block.
`timescale 1ns/1ps
// ==========================================
// Port checker.
module mrm_mode_map_monitor
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pulls and pins.
  input wire logic dbgPinPullUpEn,
  input wire logic modePinPullDownEn,
  input wire logic portEPullEn,
  input wire logic portABPullEn,
  input wire logic [7:0] portAOeN,
  input wire logic [7:0] portBOeN,
  // Access and debug.
  input wire logic cpuValid,
  input wire logic [15:0] cpuAddr,
  input wire mrm_pkg::mrm_res_t cpuResource,
  input wire logic dbgGrant,
  input wire logic backgroundDebugMode
);
  import mrm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  pulls_reset_a: assert property ($rose(rstn)
    |-> dbgPinPullUpEn && modePinPullDownEn) else $error("Pulls dropped early.");
  pulls_off_a: assert property (rstn && $past(rstn)
    |-> !dbgPinPullUpEn && !modePinPullDownEn) else $error("Pulls left on.");
  pull_levels_a: assert property (portEPullEn && !portABPullEn)
    else $error("Port pull levels wrong.");
  oe_reset_a: assert property ($rose(rstn)
    |-> portAOeN == 8'hff && portBOeN == 8'hff) else $error("Port driven at reset.");
  wait_done_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("Register access stalled.");
  rdata_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("Read data upper bits set.");
  dbg_grant_a: assert property (dbgGrant |-> !cpuValid)
    else $error("Debug granted on busy bus.");
  bdm_rom_a: assert property (backgroundDebugMode && cpuAddr > 16'hff06
    ##1 backgroundDebugMode |-> cpuResource == RES_DBG_ROM) else $error("Debug ROM missed.");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(backgroundDebugMode));
  cover property (cpuResource == RES_EXT);
endmodule

bind mrm_mode_map mrm_mode_map_monitor i_mon (.sys_clk, .rstn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .dbgPinPullUpEn, .modePinPullDownEn, .portEPullEn,
  .portABPullEn, .portAOeN, .portBOeN, .cpuValid, .cpuAddr, .cpuResource, .dbgGrant,
  .backgroundDebugMode);

// [bench/mrm_ext_mem.sv]
// External memory model on the multiplexed port A and B bus.
`timescale 1ns/1ps
// ==========================================
// Memory answering reads with a pattern of the latched address.
module mrm_ext_mem
(
  // Clock.
  input wire logic sys_clk,
  // Device side of the pins.
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOeN,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOeN,
  // Resolved pin levels.
  output logic [7:0] portAIn,
  output logic [7:0] portBIn
);
  logic [15:0] addrFf = 16'h0;
  logic [15:0] memData;
  always_ff @(posedge sys_clk)
  begin
    if (portAOeN == 8'h00)
      addrFf <= {portAOut, portBOut};
  end
  assign memData = addrFf ^ 16'h5a5a;
  // The high byte answers on port A and the low byte on port B.
  assign portAIn = (~portAOeN & portAOut) | (portAOeN & memData[15:8]);
  assign portBIn = (~portBOeN & portBOut) | (portBOeN & memData[7:0]);
endmodule

// [bench/mrm_mode_map_tb.sv]
// Self-checking bench for the mode and resource map control block.
`timescale 1ns/1ps
// ==========================================
// Bench top.
module mrm_mode_map_tb;
  import mrm_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic backgroundDebugPin = 1'b1;
  logic modeSelectB = 1'b0;
  logic modeSelectA = 1'b0;
  logic cpuValid = 1'b0;
  logic cpuWrite = 1'b0;
  logic cpuWide = 1'b1;
  logic [15:0] cpuAddr = 16'h0;
  logic [15:0] cpuWdata = 16'h0;
  logic dbgReq = 1'b0;
  logic dbgWrite = 1'b0;
  logic [15:0] dbgAddr = 16'h0;
  logic serialEntryCmd = 1'b0;
  logic backgroundEntryInstruction = 1'b0;
  logic dbgExit = 1'b0;
  logic [7:0] gpioAOut = 8'h0, gpioADir = 8'h0, gpioBOut = 8'h0, gpioBDir = 8'h0;
  logic [7:0] gpioEDir = 8'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, dbgPinPullUpEn, modePinPullDownEn, cpuReady, dbgGrant;
  logic backgroundDebugMode, skipResetVector, portEPullEn, portABPullEn, cpuHalt, eStretchHigh;
  logic [5:0] portEBusCtl;
  logic [15:0] extRdata;
  mrm_res_t cpuResource, dbgResource;
  logic [7:0] portAIn, portBIn, portAOut, portAOeN, portBOut, portBOeN, portEOeN;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;

  always #5 sys_clk = ~sys_clk;

  mrm_mode_map i_dut (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .backgroundDebugPin, .modeSelectB, .modeSelectA,
    .dbgPinPullUpEn, .modePinPullDownEn, .cpuValid, .cpuWrite, .cpuWide, .cpuAddr,
    .cpuWdata, .cpuReady, .extRdata, .cpuResource, .dbgReq, .dbgWrite, .dbgAddr, .dbgGrant,
    .dbgResource, .serialEntryCmd, .backgroundEntryInstruction, .dbgExit,
    .backgroundDebugMode, .skipResetVector, .cpuHalt, .eStretchHigh, .eStretchLow(),
    .gpioAOut, .gpioADir, .gpioBOut, .gpioBDir, .gpioEDir, .portAIn, .portBIn, .portAOut,
    .portAOeN, .portBOut, .portBOeN, .portEOeN, .portEBusCtl, .portEPullEn,
    .portABPullEn, .lowByteStrobe());
  mrm_ext_mem i_mem (.sys_clk, .portAOut, .portAOeN, .portBOut, .portBOeN, .portAIn,
    .portBIn);

  task wrap_up;
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask
  task stuck;
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask
  task avs(input logic w, input logic [5:0] a, input logic [7:0] wd);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, wd};
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20)
      stuck();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task do_reset(input logic [2:0] s);
    @(posedge sys_clk);
    rstn <= 1'b0;
    {backgroundDebugPin, modeSelectB, modeSelectA} <= s;
    repeat (3) @(posedge sys_clk);
    chk({portEPullEn, portABPullEn, portAOeN}, 32'h2ff);
    chk({dbgPinPullUpEn, modePinPullDownEn}, 32'h3);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task res(input logic [15:0] a, input mrm_res_t e);
    @(posedge sys_clk);
    cpuAddr <= a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(cpuResource, e);
  endtask
  task pulse(input logic [2:0] p);
    @(posedge sys_clk);
    {serialEntryCmd, backgroundEntryInstruction, dbgExit} <= p;
    @(posedge sys_clk);
    {serialEntryCmd, backgroundEntryInstruction, dbgExit} <= 3'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  task t_straps;
    logic [7:0] tbl [8];
    tbl = '{8'h19, 8'h39, 8'h00, 8'h79, 8'h90, 8'hb0, 8'h00, 8'hf0};
    for (int i = 0; i < 8; i++)
    begin
      do_reset(i[2:0]);
      avs(1'b0, 6'h0b, 8'h00);
      chk(rd, {24'h0, tbl[i]});
      chk(cpuHalt, i == 2 || i == 6);
      if (i == 3)
        chk({26'h0, portEBusCtl}, 32'h3f);
      if (i == 0)
        chk({backgroundDebugMode, skipResetVector}, 32'h3);
    end
  endtask
  task t_mode_writes;
    do_reset(3'b100);
    avs(1'b1, 6'h0b, 8'h00);
    avs(1'b0, 6'h0b, 8'h00);
    chk(rd, 32'h80);
    avs(1'b1, 6'h0b, 8'hbc);
    avs(1'b0, 6'h0b, 8'h00);
    chk(rd, 32'h84);
    do_reset(3'b000);
    avs(1'b1, 6'h0b, 8'h00);
    avs(1'b0, 6'h0b, 8'h00);
    chk(rd, 32'h09);
    avs(1'b1, 6'h0b, 8'h00);
    avs(1'b0, 6'h0b, 8'h00);
    chk(rd, 32'h00);
  endtask
  task t_decode;
    do_reset(3'b100);
    gpioADir <= 8'h0f;
    gpioBDir <= 8'hf0;
    gpioEDir <= 8'hff;
    gpioAOut <= 8'h5a;
    gpioBOut <= 8'ha5;
    dbgReq <= 1'b1;
    dbgAddr <= 16'h0900;
    res(16'h0000, RES_REG);
    res(16'h0800, RES_RAM);
    res(16'h0d00, RES_EEPROM);
    res(16'h9000, RES_FLASH);
    res(16'h4000, RES_NONE);
    chk({dbgGrant, dbgResource}, {1'b1, RES_RAM});
    chk({portAOeN, portBOeN, portEOeN}, 32'hf00f03);
    chk({portAOut, portBOut}, 32'h5aa5);
    avs(1'b1, 6'h10, 8'h00);
    avs(1'b1, 6'h10, 8'h08);
    avs(1'b0, 6'h10, 8'h00);
    chk(rd & 32'hf8, 32'h0);
    res(16'h0300, RES_RAM);
    res(16'h0100, RES_REG);
    avs(1'b0, 6'h3f, 8'h00);
    chk(rd, 32'h0);
  endtask
  task t_debug;
    do_reset(3'b100);
    pulse(3'h4);
    chk(backgroundDebugMode, 1'b0);
    avs(1'b1, 6'h20, 8'h80);
    pulse(3'h4);
    chk(backgroundDebugMode, 1'b1);
    res(16'hff80, RES_DBG_ROM);
    res(16'hff06, RES_DBG_REG);
    pulse(3'h1);
    chk(backgroundDebugMode, 1'b0);
    res(16'hff80, RES_FLASH);
    pulse(3'h2);
    chk(backgroundDebugMode, 1'b1);
  endtask
  task t_ext;
    int k;
    logic hi;
    do_reset(3'b111);
    @(posedge sys_clk);
    cpuAddr <= 16'h4000;
    cpuValid <= 1'b1;
    k = 0;
    hi = 1'b0;
    do
    begin
      @(negedge sys_clk);
      hi = hi | eStretchHigh;
      k++;
    end
    while (cpuReady !== 1'b1 && k < 20);
    if (k >= 20)
      stuck();
    @(posedge sys_clk);
    cpuValid <= 1'b0;
    @(negedge sys_clk);
    chk(extRdata, 16'h4000 ^ 16'h5a5a);
    chk(cpuResource, RES_EXT);
    chk(hi, 1'b1);
  endtask

  initial
  begin
    t_straps();
    t_mode_writes();
    t_decode();
    t_debug();
    t_ext();
    wrap_up();
  end
endmodule
